// ==== sbcsc_clock_source_model.sv ====
/*
 * far-side clock sources: selected oscillator, divided pll and the
 * internal oscillator, free running as real oscillators do.
 * assumes a 25 ns system clock; edges sit 5 ns after its falling edges.
 */
`timescale 1ns/10ps
`default_nettype none
module sbcsc_clock_source_model (
    output var logic osc_clk,
    output var logic pll_clk,
    output var logic int_osc_clk
);
    // ------------------------------------------------------------
    // sources, all slower than a quarter of the system clock
    // ------------------------------------------------------------
    // offset keeps every edge away from the sampling edge
    initial begin
        osc_clk = 1'b0;
        #5;
        forever #125 osc_clk = ~osc_clk;
    end
    initial begin
        pll_clk = 1'b0;
        #5;
        forever #75 pll_clk = ~pll_clk;
    end
    initial begin
        int_osc_clk = 1'b0;
        #5;
        forever #100 int_osc_clk = ~int_osc_clk;
    end
endmodule : sbcsc_clock_source_model
`default_nettype wire

// ==== sbcsc_div2.sv ====
/*
 * rising edge detector and divide-by-two toggle on one level.
 * assumes the level is synchronous to clk and changes slower than clk/2.
 */
`timescale 1ns/10ps
`default_nettype none
module sbcsc_div2 (
    input wire logic clk,
    input wire logic rst_n,
    sbcsc_div_if.divider d
);
    logic prev_q;
    logic half_q;
    wire logic rise_w;

    assign rise_w = d.lvl & ~prev_q;
    assign d.rise = rise_w;
    assign d.half = half_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            prev_q <= d.lvl;
            half_q <= half_q ^ rise_w;
        end
    end
endmodule : sbcsc_div2
`default_nettype wire

// ==== sbcsc_div_if.sv ====
/*
 * carrier between the top module and its edge/divide helper.
 * assumes lvl is already synchronised to the main clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface sbcsc_div_if;
    logic lvl;
    logic rise;
    logic half;
    modport divider (input lvl, output rise, output half);
    modport user (output lvl, input rise, input half);
endinterface : sbcsc_div_if
`default_nettype wire

// ==== sbcsc_pkg.sv ====
/*
 * constants shared by the bus clock and status control block:
 * register indices, field positions, reset values, recovery counts.
 * assumes an 8-bit register map placed on a 32-bit bus, one word each.
 */
package sbcsc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_BREAK_STATUS = 16'hFE00;
    localparam logic [15:0] IDX_RESET_CAUSE = 16'hFE01;
    localparam logic [15:0] IDX_BREAK_FLAG_CTRL = 16'hFE03;
    localparam logic [15:0] IDX_IRQ_LOW = 16'hFE04;
    localparam logic [15:0] IDX_IRQ_MID = 16'hFE05;
    localparam logic [15:0] IDX_IRQ_HIGH = 16'hFE06;
    localparam logic [15:0] IDX_RECOVERY_CFG = 16'hFE08;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BREAK_WAIT_BIT = 1;
    localparam int BREAK_CLEAR_EN_BIT = 7;
    localparam int SHORT_RECOVERY_BIT = 0;
    localparam int CAUSE_POR_BIT = 7;
    localparam int CAUSE_PIN_BIT = 6;
    localparam int CAUSE_WDOG_BIT = 5;
    localparam int CAUSE_OPCODE_BIT = 4;
    localparam int CAUSE_FETCH_BIT = 3;
    localparam int CAUSE_MONITOR_BIT = 2;
    localparam int CAUSE_LOWV_BIT = 1;
    localparam logic [7:0] CAUSE_RESET_VALUE = 8'h80;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam int IRQ_COUNT = 21;

    // ------------------------------------------------------------
    // recovery counts in internal oscillator cycles
    // ------------------------------------------------------------
    localparam int CNT_WIDTH = 13;
    localparam logic [12:0] POR_TIMEOUT_CYCLES = 13'h1000;
    localparam logic [12:0] STOP_LONG_CYCLES = 13'h1000;
    localparam logic [12:0] STOP_SHORT_CYCLES = 13'h0020;

    // ------------------------------------------------------------
    // clock state machine, gray coded along por-run-wait-stop-recover
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_POR = 3'h0,
        S_RUN = 3'h1,
        S_WAIT = 3'h3,
        S_STOP = 3'h2,
        S_RECOVER = 3'h6
    } sbcsc_state_type;

endpackage : sbcsc_pkg

// ==== sbcsc_top.sv ====
/*
 * bus clock derivation, clock gating through power-on, stop and wait,
 * and the break, reset cause and pending interrupt status registers.
 * assumes an AHB-Lite master on MCLK and clock pins sampled here;
 * the derived clocks are slow square waves rebuilt on MCLK.
 */
`timescale 1ns/10ps
`default_nettype none
module sbcsc_top #(
    parameter logic [12:0] POR_CYCLES = sbcsc_pkg::POR_TIMEOUT_CYCLES,
    parameter logic [12:0] STOP_LONG = sbcsc_pkg::STOP_LONG_CYCLES,
    parameter logic [12:0] STOP_SHORT = sbcsc_pkg::STOP_SHORT_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic OSC_CLK_PIN,
    input wire logic PLL_CLK_PIN,
    input wire logic INT_OSC_CLK_PIN,
    input wire logic PLL_SELECT_PIN,
    input wire logic LOW_VOLT_PIN,
    input wire logic RESET_PIN_I,
    output logic RESET_PIN_O,
    output logic RESET_PIN_OE,
    input wire logic STOP_REQ,
    input wire logic WAIT_REQ,
    input wire logic WAKE_EVENT,
    input wire logic BREAK_ACTIVE,
    input wire logic WDOG_RESET,
    input wire logic BAD_OPCODE,
    input wire logic BAD_FETCH,
    input wire logic MONITOR_ENTRY,
    input wire logic [sbcsc_pkg::IRQ_COUNT-1:0] IRQ_PENDING,
    output logic CLOCK_GEN_OUT,
    output logic BUS_CLK,
    output logic CPU_CLK,
    output logic PERIPH_CLK,
    output logic INTERNAL_RESET,
    output logic FLAG_CLEAR_OK
);
    import sbcsc_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // order: osc, pll, internal osc, pll select, low voltage, reset pin
    logic [5:0] pin_meta_q;
    logic [5:0] pin_sync_q;
    wire logic [5:0] pins_w;
    assign pins_w = {OSC_CLK_PIN, PLL_CLK_PIN, INT_OSC_CLK_PIN,
                     PLL_SELECT_PIN, LOW_VOLT_PIN, RESET_PIN_I};

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_meta_q <= 6'h01;
            pin_sync_q <= 6'h01;
        end else begin
            pin_meta_q <= pins_w;
            pin_sync_q <= pin_meta_q;
        end
    end

    wire logic pll_sel_w;
    wire logic low_volt_w;
    wire logic ext_reset_w;
    assign pll_sel_w = pin_sync_q[2];
    assign low_volt_w = pin_sync_q[1];
    assign ext_reset_w = ~pin_sync_q[0];

    // ------------------------------------------------------------
    // clock derivation
    // ------------------------------------------------------------
    sbcsc_div_if osc_if ();
    sbcsc_div_if pll_if ();
    sbcsc_div_if bus_if ();
    sbcsc_div_if iosc_if ();

    assign osc_if.lvl = pin_sync_q[5];
    assign pll_if.lvl = pin_sync_q[4];
    assign iosc_if.lvl = pin_sync_q[3];
    // generator output is the chosen source halved, so the bus is source / 4
    wire logic cgm_out_w;
    assign cgm_out_w = pll_sel_w ? pll_if.half : osc_if.half;
    assign bus_if.lvl = cgm_out_w;

    sbcsc_div2 u_osc_div (.clk(MCLK), .rst_n(RST_N), .d(osc_if));
    sbcsc_div2 u_pll_div (.clk(MCLK), .rst_n(RST_N), .d(pll_if));
    sbcsc_div2 u_bus_div (.clk(MCLK), .rst_n(RST_N), .d(bus_if));
    sbcsc_div2 u_iosc_edge (.clk(MCLK), .rst_n(RST_N), .d(iosc_if));

    wire logic iosc_tick_w;
    assign iosc_tick_w = iosc_if.rise;

    // ------------------------------------------------------------
    // clock state machine and recovery counter
    // ------------------------------------------------------------
    sbcsc_state_type state_q;
    sbcsc_state_type state_d;
    logic [12:0] cnt_q;
    logic [12:0] limit_q;
    logic low_volt_prev_q;
    logic short_recovery_q;

    wire logic low_volt_rise_w;
    wire logic count_done_w;
    assign low_volt_rise_w = low_volt_w & ~low_volt_prev_q;
    assign count_done_w = iosc_tick_w && (cnt_q == limit_q - 13'h0001);

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_POR: begin
                if (count_done_w) begin
                    state_d = S_RUN;
                end
            end
            S_RUN: begin
                if (STOP_REQ) begin
                    state_d = S_STOP;
                end else if (WAIT_REQ) begin
                    state_d = S_WAIT;
                end
            end
            S_WAIT: begin
                if (WAKE_EVENT) begin
                    state_d = S_RUN;
                end
            end
            S_STOP: begin
                if (WAKE_EVENT) begin
                    state_d = S_RECOVER;
                end
            end
            S_RECOVER: begin
                if (count_done_w) begin
                    state_d = S_RUN;
                end
            end
            default: begin
                state_d = S_POR;
            end
        endcase
        if (low_volt_rise_w) begin
            state_d = S_POR;
        end
    end

    // the counter restarts whenever a timed phase begins
    wire logic cnt_clear_w;
    assign cnt_clear_w = (state_d != state_q) || (state_q != S_POR && state_q != S_RECOVER);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= S_POR;
            cnt_q <= 13'h0000;
            limit_q <= POR_CYCLES;
            low_volt_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            low_volt_prev_q <= low_volt_w;
            if (cnt_clear_w) begin
                cnt_q <= 13'h0000;
            end else if (iosc_tick_w) begin
                cnt_q <= cnt_q + 13'h0001;
            end
            if (state_d == S_POR && state_q != S_POR) begin
                limit_q <= POR_CYCLES;
            end else if (state_d == S_RECOVER && state_q != S_RECOVER) begin
                limit_q <= short_recovery_q ? STOP_SHORT : STOP_LONG;
            end
        end
    end

    // ------------------------------------------------------------
    // gated clock outputs and reset pin
    // ------------------------------------------------------------
    wire logic cpu_on_w;
    wire logic periph_on_w;
    assign cpu_on_w = (state_q == S_RUN);
    assign periph_on_w = (state_q == S_RUN) || (state_q == S_WAIT);

    logic cgm_out_q;
    logic bus_clk_q;
    logic cpu_clk_q;
    logic periph_clk_q;
    logic reset_oe_q;
    logic int_reset_q;

    // a reset event other than power loss holds the internal reset while the event lasts
    wire logic reset_event_w;
    assign reset_event_w = ext_reset_w | WDOG_RESET | BAD_OPCODE | BAD_FETCH | MONITOR_ENTRY;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cgm_out_q <= 1'b0;
            bus_clk_q <= 1'b0;
            cpu_clk_q <= 1'b0;
            periph_clk_q <= 1'b0;
            reset_oe_q <= 1'b1;
            int_reset_q <= 1'b1;
        end else begin
            cgm_out_q <= cgm_out_w;
            bus_clk_q <= bus_if.half;
            // inactive phase is low while gated
            cpu_clk_q <= bus_if.half & cpu_on_w;
            periph_clk_q <= bus_if.half & periph_on_w;
            reset_oe_q <= (state_d == S_POR);
            int_reset_q <= (state_d == S_POR) | reset_event_w;
        end
    end

    assign CLOCK_GEN_OUT = cgm_out_q;
    assign BUS_CLK = bus_clk_q;
    assign CPU_CLK = cpu_clk_q;
    assign PERIPH_CLK = periph_clk_q;
    assign RESET_PIN_OE = reset_oe_q;
    assign RESET_PIN_O = 1'b0;
    assign INTERNAL_RESET = int_reset_q;

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    logic wr_pend_q;
    logic [17:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic ready_q;

    wire logic access_w;
    assign access_w = HSEL & HTRANS[1] & HREADY;

    function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic break_wait_q;
    logic clear_en_q;
    logic [7:0] cause_q;
    logic [IRQ_COUNT-1:0] irq_q;

    wire logic wr_break_w;
    wire logic wr_ctrl_w;
    wire logic wr_recov_w;
    assign wr_break_w = wr_pend_q & hit(wr_addr_q, IDX_BREAK_STATUS);
    assign wr_ctrl_w = wr_pend_q & hit(wr_addr_q, IDX_BREAK_FLAG_CTRL);
    assign wr_recov_w = wr_pend_q & hit(wr_addr_q, IDX_RECOVERY_CFG);

    wire logic break_wait_set_w;
    wire logic break_wait_clr_w;
    assign break_wait_set_w = BREAK_ACTIVE & (state_q == S_WAIT);
    assign break_wait_clr_w = wr_break_w & ~HWDATA[BREAK_WAIT_BIT];

    wire logic [7:0] cause_event_w;
    assign cause_event_w = {1'b0, ext_reset_w, WDOG_RESET, BAD_OPCODE,
                            BAD_FETCH, MONITOR_ENTRY, low_volt_rise_w, 1'b0};

    wire logic [7:0] irq_low_w;
    wire logic [7:0] irq_mid_w;
    wire logic [7:0] irq_high_w;
    assign irq_low_w = {irq_q[5:0], 2'b00};
    assign irq_mid_w = irq_q[13:6];
    assign irq_high_w = {1'b0, irq_q[20:14]};

    wire logic [17:0] ra_w;
    wire logic [7:0] rd_byte_w;
    assign ra_w = HADDR[17:0];
    assign rd_byte_w =
        hit(ra_w, IDX_BREAK_STATUS) ? {6'h00, break_wait_q, 1'b0} :
        hit(ra_w, IDX_RESET_CAUSE) ? cause_q :
        hit(ra_w, IDX_BREAK_FLAG_CTRL) ? {clear_en_q, 7'h00} :
        hit(ra_w, IDX_IRQ_LOW) ? irq_low_w :
        hit(ra_w, IDX_IRQ_MID) ? irq_mid_w :
        hit(ra_w, IDX_IRQ_HIGH) ? irq_high_w :
        hit(ra_w, IDX_RECOVERY_CFG) ? {7'h00, short_recovery_q} : 8'h00;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 18'h00000;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            wr_pend_q <= access_w & HWRITE;
            if (access_w) begin
                wr_addr_q <= ra_w;
            end
            if (access_w & ~HWRITE) begin
                rdata_q <= {24'h000000, rd_byte_w};
            end
        end
    end

    // software registers clear on the internal reset too
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            break_wait_q <= 1'b0;
            clear_en_q <= 1'b0;
            short_recovery_q <= 1'b0;
            irq_q <= '0;
        end else if (int_reset_q) begin
            break_wait_q <= 1'b0;
            clear_en_q <= 1'b0;
            short_recovery_q <= 1'b0;
            irq_q <= '0;
        end else begin
            irq_q <= IRQ_PENDING;
            if (break_wait_set_w) begin
                break_wait_q <= 1'b1;
            end else if (break_wait_clr_w) begin
                break_wait_q <= 1'b0;
            end
            if (wr_ctrl_w) begin
                clear_en_q <= HWDATA[BREAK_CLEAR_EN_BIT];
            end
            if (wr_recov_w) begin
                short_recovery_q <= HWDATA[SHORT_RECOVERY_BIT];
            end
        end
    end

    // cause keeps the sources seen in the newest event cycle only; only the power-on reset sets the por flag
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cause_q <= CAUSE_RESET_VALUE;
        end else if (cause_event_w != 8'h00) begin
            cause_q <= cause_event_w;
        end
    end

    // flags elsewhere may clear only outside break, or when enabled
    logic clear_ok_q;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            clear_ok_q <= 1'b1;
        end else begin
            clear_ok_q <= ~BREAK_ACTIVE | clear_en_q;
        end
    end

    assign FLAG_CLEAR_OK = clear_ok_q;
    assign HRDATA = rdata_q;
    assign HREADYOUT = ready_q;
    assign HRESP = 1'b0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_por_pin_low: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_q == S_POR) |-> RESET_PIN_OE)
        else $error("reset pin released during start-up");
    chk_por_end_run: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_q == S_POR && count_done_w && !low_volt_rise_w) |=> (state_q == S_RUN))
        else $error("clocks not started after timeout");
    chk_gated_cpu_off: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_q != S_RUN) |=> !CPU_CLK)
        else $error("cpu clock running while gated");
    chk_wait_periph_on: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_q == S_WAIT && bus_if.half) |=> (PERIPH_CLK && !CPU_CLK))
        else $error("wait mode clock gating wrong");
    chk_bus_half_rate: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(cgm_out_w) |=> (bus_if.half != $past(bus_if.half)))
        else $error("bus clock did not toggle on generator edge");
    chk_recover_limit: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_q == S_RECOVER) |-> ((limit_q == STOP_SHORT || limit_q == STOP_LONG)
            && cnt_q < limit_q))
        else $error("stop recovery count out of range");
    chk_recover_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_q == S_RECOVER && !count_done_w) |=> (state_q != S_RUN))
        else $error("clocks resumed before stop delay");
    chk_break_set_wins: assert property (@(posedge MCLK) disable iff (!RST_N)
        (break_wait_set_w && !int_reset_q) |=> break_wait_q)
        else $error("break-wait flag not set");
    chk_break_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
        (break_wait_clr_w && !break_wait_set_w) |=> !break_wait_q)
        else $error("break-wait flag not cleared by zero write");
    chk_clear_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
        (BREAK_ACTIVE && !clear_en_q) |=> !FLAG_CLEAR_OK)
        else $error("flag clearing allowed during break");
    chk_irq_high_bit7: assert property (@(posedge MCLK) disable iff (!RST_N)
        (access_w && !HWRITE && hit(ra_w, IDX_IRQ_HIGH)) |=> (HRDATA[7] == 1'b0))
        else $error("unused pending bit reads one");

endmodule : sbcsc_top
`default_nettype wire

// ==== system_bus_clock_and_status_control_tb.sv ====
/*
 * self-checking bench: bus master, register model, clock and state checks.
 * assumes the clock source model and a zero-wait register slave.
 */
`timescale 1ns/10ps
`default_nettype none
module system_bus_clock_and_status_control_tb;
    import sbcsc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int P = 16;
    localparam int SL = 16;
    localparam int SS = 4;
    logic mclk, rst_n, hsel, hwrite, pll_sel, low_v, pin_i, stop_r, wait_r, wake, brk;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [3:0] ev;
    logic [20:0] irq;
    logic hready, hresp, osc, pll, iosc, pin_o, pin_oe, gen, bus_c, cpu, per, internal_reset, fco;
    logic [7:0] mdl [logic [15:0]];
    int n_errors = 0;
    int samples_checked = 0;
    int cpu_hi;
    sbcsc_clock_source_model i_sbcsc_clock_source_model (.osc_clk(osc), .pll_clk(pll),
        .int_osc_clk(iosc));
    sbcsc_top #(.POR_CYCLES(13'(P)), .STOP_LONG(13'(SL)), .STOP_SHORT(13'(SS))) i_sbcsc_top (
        .MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .OSC_CLK_PIN(osc), .PLL_CLK_PIN(pll),
        .INT_OSC_CLK_PIN(iosc), .PLL_SELECT_PIN(pll_sel), .LOW_VOLT_PIN(low_v),
        .RESET_PIN_I(pin_i), .RESET_PIN_O(pin_o), .RESET_PIN_OE(pin_oe), .STOP_REQ(stop_r),
        .WAIT_REQ(wait_r), .WAKE_EVENT(wake), .BREAK_ACTIVE(brk), .WDOG_RESET(ev[0]),
        .BAD_OPCODE(ev[1]), .BAD_FETCH(ev[2]), .MONITOR_ENTRY(ev[3]), .IRQ_PENDING(irq),
        .CLOCK_GEN_OUT(gen), .BUS_CLK(bus_c), .CPU_CLK(cpu), .PERIPH_CLK(per),
        .INTERNAL_RESET(internal_reset), .FLAG_CLEAR_OK(fco));
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic hang();
        n_errors++;
        print_verdict();
    endtask : hang
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) hang();
    endtask : wait_rdy
    // one single word transfer; the model follows every write
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
        if (wr && idx == IDX_BREAK_STATUS && !wd[1]) mdl[idx] = 8'h00;
        if (wr && idx == IDX_BREAK_FLAG_CTRL) mdl[idx] = wd & 8'h80;
        if (wr && idx == IDX_RECOVERY_CFG) mdl[idx] = wd & 8'h01;
    endtask : bus
    task automatic rdchk(input logic [15:0] idx);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, rd);
        chk(rd, {24'h0, mdl[idx]});
    endtask : rdchk
    // counts oscillator rises until the pin is released or peripherals run
    task automatic count_osc(input logic sel, output int n);
        logic prev;
        n = 0;
        cpu_hi = 0;
        prev = iosc;
        for (int k = 0; k < 4000; k++) begin
            @(posedge mclk);
            if (iosc && !prev) n++;
            prev = iosc;
            if (sel ? (per === 1'b1) : (pin_oe === 1'b0)) return;
            if (cpu === 1'b1) cpu_hi++;
        end
        hang();
    endtask : count_osc
    task automatic period(input logic sel, output int n);
        logic prev, cur;
        n = -1;
        prev = 1'b1;
        for (int k = 0; k < 300; k++) begin
            @(posedge mclk);
            cur = sel ? bus_c : gen;
            if (n >= 0) n++;
            if (cur && !prev) begin
                if (n > 0) return;
                n = 0;
            end
            prev = cur;
        end
        hang();
    endtask : period
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [31:0] rd;
        logic pv;
        {rst_n, hsel, hwrite, pll_sel, low_v, stop_r, wait_r, wake, brk} = '0;
        {haddr, hwdata, htrans, ev, irq} = '0;
        pin_i = 1'b1;
        mdl[IDX_BREAK_STATUS] = 8'h00;
        mdl[IDX_RESET_CAUSE] = 8'h80;
        mdl[16'hFE02] = 8'h00;
        mdl[IDX_BREAK_FLAG_CTRL] = 8'h00;
        mdl[IDX_RECOVERY_CFG] = 8'h00;
        void'($urandom(32'h0af7));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        count_osc(1'b0, n);
        chk(32'(n >= P - 1 && n <= P + 1), 1);
        chk(cpu_hi, 0);
        chk(pin_o, 0);
        for (int i = 0; i < 7; i++) begin
            if (i > 3) mdl[IDX_IRQ_LOW + 16'(i - 4)] = 8'h00;
            rdchk(i > 3 ? IDX_IRQ_LOW + 16'(i - 4) : IDX_BREAK_STATUS + 16'(i));
        end
        for (int s = 0; s < 2; s++) begin
            pll_sel <= s[0];
            repeat (40) @(posedge mclk);
            period(1'b0, n);
            chk(n, s ? 12 : 20);
            period(1'b1, n);
            chk(n, s ? 24 : 40);
        end
        pll_sel <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, IDX_BREAK_FLAG_CTRL, 8'($urandom), rd);
            rdchk(IDX_BREAK_FLAG_CTRL);
            bus(1'b1, IDX_RESET_CAUSE, 8'($urandom), rd);
            rdchk(IDX_RESET_CAUSE);
            irq <= 21'($urandom);
            repeat (3) @(posedge mclk);
            mdl[IDX_IRQ_LOW] = {irq[5:0], 2'b00};
            mdl[IDX_IRQ_MID] = irq[13:6];
            mdl[IDX_IRQ_HIGH] = {1'b0, irq[20:14]};
            for (int j = 0; j < 3; j++) rdchk(IDX_IRQ_LOW + 16'(j));
            chk(hresp, 0);
        end
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, IDX_BREAK_FLAG_CTRL, {s[0], 7'h0}, rd);
            brk <= 1'b1;
            repeat (3) @(posedge mclk);
            chk(fco, s[0]);
            brk <= 1'b0;
        end
        wait_r <= 1'b1;
        @(posedge mclk);
        wait_r <= 1'b0;
        repeat (3) @(posedge mclk);
        count_osc(1'b1, n);
        brk <= 1'b1;
        repeat (30) @(posedge mclk);
        chk(cpu_hi, 0);
        chk(cpu, 0);
        brk <= 1'b0;
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        mdl[IDX_BREAK_STATUS] = 8'h02;
        rdchk(IDX_BREAK_STATUS);
        bus(1'b1, IDX_BREAK_STATUS, 8'hFF, rd);
        rdchk(IDX_BREAK_STATUS);
        bus(1'b1, IDX_BREAK_STATUS, 8'h00, rd);
        rdchk(IDX_BREAK_STATUS);
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, IDX_RECOVERY_CFG, {7'h0, s[0]}, rd);
            stop_r <= 1'b1;
            @(posedge mclk);
            stop_r <= 1'b0;
            repeat (60) @(posedge mclk);
            // wake two edges after an oscillator rise, so no tick is in flight
            pv = iosc;
            for (int k = 0; k < 10 && !(iosc && !pv); k++) begin
                pv = iosc;
                @(posedge mclk);
            end
            if (!(iosc && !pv)) hang();
            repeat (2) @(posedge mclk);
            wake <= 1'b1;
            @(posedge mclk);
            wake <= 1'b0;
            count_osc(1'b1, n);
            chk(32'(n >= (s ? SS : SL) && n <= (s ? SS : SL) + 7), 1);
            chk(cpu_hi, 0);
        end
        for (int i = 0; i < 5; i++) begin
            if (i < 4) ev <= 4'h1 << i;
            else pin_i <= 1'b0;
            repeat (4) @(posedge mclk);
            chk(internal_reset, 1);
            {ev, pin_i} <= 5'h01;
            repeat (6) @(posedge mclk);
            chk(internal_reset, 0);
            mdl[IDX_RESET_CAUSE] = i < 4 ? 8'h20 >> i : 8'h40;
            mdl[IDX_BREAK_FLAG_CTRL] = 8'h00;
            rdchk(IDX_RESET_CAUSE);
            rdchk(IDX_BREAK_FLAG_CTRL);
        end
        low_v <= 1'b1;
        repeat (4) @(posedge mclk);
        low_v <= 1'b0;
        chk(pin_oe, 1);
        count_osc(1'b0, n);
        chk(32'(n >= P - 2 && n <= P + 1), 1);
        mdl[IDX_RESET_CAUSE] = 8'h02;
        rdchk(IDX_RESET_CAUSE);
        print_verdict();
    end
endmodule : system_bus_clock_and_status_control_tb
`default_nettype wire
